// File: tone_output_stage_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tone_output_stage_tb;
    logic clock = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h00000000, dr;
    logic tv = 1'b0, seq_end = 1'b0, run = 1'b0, clr = 1'b0;
    logic [15:0] ts = 16'h4000;
    logic [3:0] sel = 4'hF, lanes = 4'hF;
    logic signed [15:0] third_s = 16'sh0000, extra_s = 16'sh0000;
    wire [31:0] dat_o;
    wire ack, tr, strobe, sq, spk, wsq, addx, dial, tx_hit, rx_hit;
    wire signed [15:0] tx, rx, tx_peak;
    integer num_errors = 0, total_checks = 0, i, t0, t1, dial_exp;
    initial forever #12.5 clock = ~clock;
    tos_output_stage #(.UNIT_CYCLES(8), .FIFO_DEPTH(16), .FIFO_AW(4)) dut_u (.clock(clock), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .tone_valid(tv), .tone_ready(tr), .tone_sample(ts),
        .sequence_end(seq_end), .third_gen_sample(third_s), .extra_gen_sample(extra_s),
        .sample_strobe(strobe), .tx_tone(tx), .rx_tone(rx), .speaker_square(sq), .speaker_active(spk),
        .waveform_square(wsq), .add_extra_generator(addx), .dial_tone_mode(dial));
    tos_codec_model #(.PERIOD(4)) codec_u (.clock(clock), .reset(reset), .run(run), .clear(clr),
        .tx_tone(tx), .rx_tone(rx), .sample_strobe(strobe), .tx_hit(tx_hit), .rx_hit(rx_hit),
        .tx_peak(tx_peak));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d; sel <= lanes;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        dr = dat_o;
        if (n >= 50) check("ack", 0, 1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    task t_regs;
        rd(8'h00); check("config", dr, 32'h00000000);
        rd(8'h08); check("on_period", dr, 32'h00000001);
        rd(8'h0C); check("off_period", dr, 32'h00000001);
        rd(8'h14); check("levels", dr, 32'h00000000);
        lanes = 4'h2;
        xfer(1'b1, 8'h14, 32'hFFFFABFF);
        lanes = 4'hF;
        rd(8'h14); check("byte_lane", dr, 32'h0000AB00);
        xfer(1'b1, 8'h1C, 32'hFFFFFFFF); rd(8'h1C); check("unmapped", dr, 32'h00000000);
        xfer(1'b1, 8'h00, 32'hFFFFFFFF); rd(8'h00); check("config_width", dr, 32'h0000001F);
        xfer(1'b1, 8'h00, 32'h0);
    endtask
    task t_fifo;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            if (tr !== 1'b1) break;
            tv <= 1'b1;
            @(posedge clock);
            tv <= 1'b0;
        end
        check("fifo_words", i, 16);
        rd(8'h18); check("fifo_count", dr[12:8], 16);
        run <= 1'b1;
        repeat (80) @(posedge clock);
        rd(8'h18); check("fifo_drained", dr[12:8], 0);
        run <= 1'b0;
    endtask
    task t_gate;
        rd(8'h18); check("gate_idle", dr[0], 0);
        xfer(1'b1, 8'h00, 32'h1);
        for (i = 0; i < 12; i++)
        begin
            rd(8'h18); check("gate_cont", dr[0], 1);
        end
        xfer(1'b1, 8'h08, 32'h1); xfer(1'b1, 8'h0C, 32'h3);
        xfer(1'b1, 8'h00, 32'h3);
        i = 0; do begin rd(8'h18); i++; end while (dr[0] !== 1'b0 && i < 40);
        t0 = $time / 25;
        i = 0; do begin rd(8'h18); i++; end while (dr[0] !== 1'b1 && i < 40);
        t1 = $time / 25;
        check("off_len", (t1 - t0 >= 21) && (t1 - t0 <= 27), 1);
        i = 0; do begin rd(8'h18); i++; end while (dr[0] !== 1'b0 && i < 40);
        check("on_len", ($time / 25 - t1 >= 5) && ($time / 25 - t1 <= 11), 1);
        xfer(1'b1, 8'h00, 32'h0);
    endtask
    task t_stop;
        xfer(1'b1, 8'h00, 32'h5); xfer(1'b1, 8'h00, 32'h4);
        rd(8'h18); check("drain_gate", dr[2:0], 3'b101);
        @(posedge clock); seq_end <= 1'b1;
        @(posedge clock); seq_end <= 1'b0;
        rd(8'h18); check("stopped", dr[0], 0);
        xfer(1'b1, 8'h00, 32'h0);
    endtask
    task t_paths;
        // Third gain sits 2 dB under the extra gain
        xfer(1'b1, 8'h00, 32'h1); xfer(1'b1, 8'h14, 32'hFFCB40FF); xfer(1'b1, 8'h04, 32'h1);
        clr <= 1'b1; @(posedge clock); clr <= 1'b0; tv <= 1'b1; run <= 1'b1;
        repeat (40) @(posedge clock);
        check("tx_tone", tx_hit, 1);
        check("rx_mute", rx_hit, 0);
        check("square_sel", wsq, 0);
        // Filter in, gate off: equalizer history settles to zero
        xfer(1'b1, 8'h00, 32'h10); xfer(1'b1, 8'h10, 32'hFFFF0000);
        repeat (20) @(posedge clock);
        clr <= 1'b1; @(posedge clock); clr <= 1'b0;
        xfer(1'b1, 8'h00, 32'h11);
        repeat (40) @(posedge clock);
        check("sat_peak", tx_peak, 32767 * 255 / 256);
        check("eq_dc", tx, 0);
        xfer(1'b1, 8'h04, 32'h4);
        repeat (10) @(posedge clock);
        check("direct_sq", wsq, 1);
        check("spk_active", spk, 1);
        check("spk_square", sq, 1);
        // Extra-generator flag stays off while dial-tone mode is tested; the extra sample still enters the dial sum
        xfer(1'b1, 8'h04, 32'h8);
        third_s <= 16'sh1000; extra_s <= 16'sh0800;
        check("dial_mode", {dial, addx}, 2'b10);
        dial_exp = 4096 * 203 / 256 + 2048 * 255 / 256;
        repeat (200) @(posedge clock);
        check("dial_tx", (tx <= dial_exp) && (tx >= dial_exp - 3), 1);
        xfer(1'b1, 8'h04, 32'h10);
        check("extra_gen", {dial, addx}, 2'b01);
        tv <= 1'b0; run <= 1'b0;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        t_regs; t_fifo; t_gate; t_stop; t_paths;
        print_verdict;
    end
    initial
    begin
        #(25 * 20000);
        num_errors++;
        print_verdict;
    end
endmodule // tone_output_stage_tb
bind tos_output_stage tos_output_stage_monitor mon_u (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_strobe(sample_strobe), .tx_tone(tx_tone), .rx_tone(rx_tone), .speaker_active(speaker_active));
`default_nettype wire

// File: tos_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module tos_codec_model #(
    parameter PERIOD = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    input wire logic clear,
    input wire logic signed [15:0] tx_tone,
    input wire logic signed [15:0] rx_tone,
    output logic sample_strobe,
    output logic tx_hit,
    output logic rx_hit,
    output logic signed [15:0] tx_peak
);
    integer cnt;
    logic taken;
    always @(posedge clock)
    begin
        if (reset || clear)
        begin
            cnt <= 0;
            sample_strobe <= 1'b0;
            taken <= 1'b0;
            tx_hit <= 1'b0;
            rx_hit <= 1'b0;
            tx_peak <= 16'sh0000;
        end
        else
        begin
            // One sample per codec period
            sample_strobe <= run && (cnt == PERIOD - 1);
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            taken <= sample_strobe;
            if (taken && tx_tone != 16'sh0000) tx_hit <= 1'b1;
            if (taken && rx_tone != 16'sh0000) rx_hit <= 1'b1;
            // Highest transmit sample since the last clear
            if (taken && tx_tone > tx_peak) tx_peak <= tx_tone;
        end
    end
endmodule // tos_codec_model
`default_nettype wire

// File: tos_fifo.v
`timescale 1ns/1ps
`default_nettype none

module tos_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output reg [AW:0] count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clock)
    begin
        if (reset)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule // tos_fifo
`default_nettype wire

// File: tos_output_stage.v
`timescale 1ns/1ps
`default_nettype none
`include "tos_regs.vh"

module tos_output_stage #(
    parameter UNIT_CYCLES = `TOS_UNIT_CYCLES,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clock,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire tone_valid,
    output wire tone_ready,
    input wire [15:0] tone_sample,
    input wire sequence_end,
    input wire signed [15:0] third_gen_sample,
    input wire signed [15:0] extra_gen_sample,
    input wire sample_strobe,
    output reg signed [15:0] tx_tone,
    output reg signed [15:0] rx_tone,
    output reg speaker_square,
    output reg speaker_active,
    output wire waveform_square,
    output wire add_extra_generator,
    output wire dial_tone_mode
);
    localparam ST_IDLE = 2'b00;
    localparam ST_ON = 2'b01;
    localparam ST_OFF = 2'b10;
    localparam ST_DRAIN = 2'b11;

    reg [`TOS_CFG_WIDTH-1:0] tone_config_reg;
    reg [`TOS_SW_WIDTH-1:0] tone_switch_reg;
    reg [15:0] on_period;
    reg [15:0] off_period;
    reg [31:0] filter_word;
    reg [31:0] level_word;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [31:0] unit_count;
    reg [15:0] period_count;
    reg [15:0] next_period_count;
    wire unit_tick;

    reg signed [15:0] eq_x1;
    reg signed [15:0] eq_x2;
    reg signed [15:0] eq_y1;
    reg signed [15:0] eq_y2;
    reg signed [15:0] lp_state;

    wire tone_enable;
    wire pulsed_mode;
    wire stop_at_sequence_end;
    wire waveform_select;
    wire filter_insert;
    wire tone_to_tx;
    wire tone_to_rx;
    wire direct_speaker_route;
    wire gate;
    wire bus_req;
    wire [31:0] cfg_merged;
    wire [31:0] sw_merged;
    wire [31:0] on_merged;
    wire [31:0] off_merged;
    wire [FIFO_AW:0] fifo_count;
    wire fifo_valid;
    wire [15:0] fifo_data;
    wire signed [15:0] raw_tone;
    wire signed [15:0] gated_tone;
    wire signed [15:0] eq_out;
    wire signed [15:0] sat_out;
    wire signed [15:0] shaped_tone;
    wire signed [15:0] tx_scaled;
    wire signed [15:0] rx_scaled;
    wire signed [15:0] third_scaled;
    wire signed [15:0] extra_scaled;
    wire signed [15:0] dial_sum;
    wire signed [15:0] lp_next;

    // Saturating conversion of a wide sum to a sample
    function signed [15:0] clip16;
        input signed [31:0] value;
        begin
            if (value > 32'sh00007FFF)
                clip16 = 16'sh7FFF;
            else if (value < -32'sh00008000)
                clip16 = -16'sh8000;
            else
                clip16 = value[15:0];
        end
    endfunction

    // Byte-enable merge of a write into a register word
    function [31:0] merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0] sel;
        integer i;
        begin
            merge = old_word;
            for (i = 0; i < 4; i = i + 1)
                if (sel[i])
                    merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
    endfunction

    // A zero period still lasts one unit
    function [15:0] period_load;
        input [15:0] value;
        begin
            period_load = (value == 16'h0000) ? 16'h0001 : value;
        end
    endfunction

    assign tone_enable = tone_config_reg[`TOS_CFG_TONE_ENABLE];
    assign pulsed_mode = tone_config_reg[`TOS_CFG_PULSED_MODE];
    assign stop_at_sequence_end = tone_config_reg[`TOS_CFG_STOP_AT_END];
    assign waveform_select = tone_config_reg[`TOS_CFG_WAVEFORM_SELECT];
    assign filter_insert = tone_config_reg[`TOS_CFG_FILTER_INSERT];
    assign tone_to_tx = tone_switch_reg[`TOS_SW_TONE_TO_TX];
    assign tone_to_rx = tone_switch_reg[`TOS_SW_TONE_TO_RX];
    assign direct_speaker_route = tone_switch_reg[`TOS_SW_DIRECT_SPEAKER];
    assign dial_tone_mode = tone_switch_reg[`TOS_SW_DIAL_TONE_MODE];
    assign add_extra_generator = tone_switch_reg[`TOS_SW_ADD_EXTRA_GEN];

    // Generators forced to square on the speaker route
    assign waveform_square = direct_speaker_route | waveform_select;

    // Register bus
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign cfg_merged = merge({27'h0000000, tone_config_reg}, wb_dat_i, wb_sel_i);
    assign sw_merged = merge({27'h0000000, tone_switch_reg}, wb_dat_i, wb_sel_i);
    assign on_merged = merge({16'h0000, on_period}, wb_dat_i, wb_sel_i);
    assign off_merged = merge({16'h0000, off_period}, wb_dat_i, wb_sel_i);

    always @(posedge clock)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `TOS_RST_WORD;
            tone_config_reg <= {`TOS_CFG_WIDTH{1'b0}};
            tone_switch_reg <= {`TOS_SW_WIDTH{1'b0}};
            on_period <= `TOS_RST_PERIOD;
            off_period <= `TOS_RST_PERIOD;
            filter_word <= `TOS_RST_WORD;
            level_word <= `TOS_RST_WORD;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= `TOS_RST_WORD;
            if (bus_req & wb_we_i)
            begin
                case (wb_adr_i)
                    `TOS_ADR_CONFIG:
                        tone_config_reg <= cfg_merged[`TOS_CFG_WIDTH-1:0];
                    `TOS_ADR_SWITCH:
                        tone_switch_reg <= sw_merged[`TOS_SW_WIDTH-1:0];
                    `TOS_ADR_ON_PERIOD:
                        on_period <= on_merged[`TOS_HALF0];
                    `TOS_ADR_OFF_PERIOD:
                        off_period <= off_merged[`TOS_HALF0];
                    `TOS_ADR_FILTER:
                        filter_word <= merge(filter_word, wb_dat_i, wb_sel_i);
                    `TOS_ADR_LEVELS:
                        level_word <= merge(level_word, wb_dat_i, wb_sel_i);
                    default:
                        wb_dat_o <= `TOS_RST_WORD;
                endcase
            end
            else if (bus_req)
            begin
                case (wb_adr_i)
                    `TOS_ADR_CONFIG:
                        wb_dat_o <= {27'h0000000, tone_config_reg};
                    `TOS_ADR_SWITCH:
                        wb_dat_o <= {27'h0000000, tone_switch_reg};
                    `TOS_ADR_ON_PERIOD:
                        wb_dat_o <= {16'h0000, on_period};
                    `TOS_ADR_OFF_PERIOD:
                        wb_dat_o <= {16'h0000, off_period};
                    `TOS_ADR_FILTER:
                        wb_dat_o <= filter_word;
                    `TOS_ADR_LEVELS:
                        wb_dat_o <= level_word;
                    `TOS_ADR_STATUS:
                    begin
                        wb_dat_o <= `TOS_RST_WORD;
                        wb_dat_o[`TOS_ST_GATE] <= gate;
                        wb_dat_o[`TOS_ST_OFF_PHASE] <= (state == ST_OFF);
                        wb_dat_o[`TOS_ST_DRAINING] <= (state == ST_DRAIN);
                        wb_dat_o[`TOS_ST_COUNT_LSB +: FIFO_AW+1] <= fifo_count;
                    end
                    default:
                        wb_dat_o <= `TOS_RST_WORD;
                endcase
            end
        end
    end

    // Period time base
    assign unit_tick = (unit_count == UNIT_CYCLES - 1);

    always @(posedge clock)
    begin
        if (reset | unit_tick | (state == ST_IDLE))
            unit_count <= 32'h00000000;
        else
            unit_count <= unit_count + 32'h00000001;
    end

    // Control generator
    always @*
    begin
        next_state = state;
        next_period_count = period_count;
        case (state)
            ST_IDLE:
            begin
                if (pulsed_mode)
                begin
                    next_state = ST_ON;
                    next_period_count = period_load(on_period);
                end
                else if (tone_enable)
                    next_state = ST_ON;
            end
            ST_ON:
            begin
                if (~tone_enable & ~pulsed_mode)
                    next_state = stop_at_sequence_end ? ST_DRAIN : ST_IDLE;
                else if (pulsed_mode & unit_tick)
                begin
                    if (period_count <= 16'h0001)
                    begin
                        next_state = ST_OFF;
                        next_period_count = period_load(off_period);
                    end
                    else
                        next_period_count = period_count - 16'h0001;
                end
            end
            ST_OFF:
            begin
                if (~tone_enable & ~pulsed_mode)
                    next_state = ST_IDLE;
                else if (~pulsed_mode)
                    next_state = ST_ON;
                else if (unit_tick)
                begin
                    if (period_count <= 16'h0001)
                    begin
                        next_state = ST_ON;
                        next_period_count = period_load(on_period);
                    end
                    else
                        next_period_count = period_count - 16'h0001;
                end
            end
            ST_DRAIN:
            begin
                if (tone_enable | pulsed_mode)
                begin
                    next_state = ST_ON;
                    next_period_count = period_load(on_period);
                end
                else if (sequence_end)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge clock)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            period_count <= `TOS_RST_PERIOD;
        end
        else
        begin
            state <= next_state;
            period_count <= next_period_count;
        end
    end

    assign gate = (state == ST_ON) | (state == ST_DRAIN);

    // Incoming tone samples, drained once per codec sample
    tos_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_valid(tone_valid),
        .in_ready(tone_ready),
        .in_data(tone_sample),
        .out_valid(fifo_valid),
        .out_ready(sample_strobe),
        .out_data(fifo_data),
        .count(fifo_count)
    );

    assign raw_tone = fifo_valid ? $signed(fifo_data) : 16'sh0000;
    assign gated_tone = gate ? raw_tone : 16'sh0000;

    // Band-pass equalizer
    assign eq_out = clip16(((($signed({{16{gated_tone[15]}}, gated_tone}) - $signed({{16{eq_x2[15]}}, eq_x2}))
        * $signed({1'b0, filter_word[`TOS_BYTE2]})) >>> `TOS_SHIFT_ATTEN)
        + (($signed({{16{eq_y1[15]}}, eq_y1}) * $signed(filter_word[`TOS_BYTE0])) >>> `TOS_SHIFT_CENTRE)
        + (($signed({{16{eq_y2[15]}}, eq_y2}) * $signed(filter_word[`TOS_BYTE1])) >>> `TOS_SHIFT_BAND));

    tos_scale #(.SHIFT(`TOS_SHIFT_SAT)) u_sat (
        .sample(eq_out),
        .coef(filter_word[`TOS_BYTE3]),
        .scaled(sat_out)
    );

    assign shaped_tone = filter_insert ? sat_out : gated_tone;

    tos_scale #(.SHIFT(`TOS_SHIFT_LEVEL)) u_tx (
        .sample(shaped_tone),
        .coef(level_word[`TOS_BYTE0]),
        .scaled(tx_scaled)
    );

    tos_scale #(.SHIFT(`TOS_SHIFT_LEVEL)) u_rx (
        .sample(shaped_tone),
        .coef(level_word[`TOS_BYTE1]),
        .scaled(rx_scaled)
    );

    tos_scale #(.SHIFT(`TOS_SHIFT_LEVEL)) u_third (
        .sample(third_gen_sample),
        .coef(level_word[`TOS_BYTE2]),
        .scaled(third_scaled)
    );

    tos_scale #(.SHIFT(`TOS_SHIFT_LEVEL)) u_extra (
        .sample(extra_gen_sample),
        .coef(level_word[`TOS_BYTE3]),
        .scaled(extra_scaled)
    );

    assign dial_sum = clip16({{16{third_scaled[15]}}, third_scaled}
        + {{16{extra_scaled[15]}}, extra_scaled});
    assign lp_next = clip16($signed({{16{lp_state[15]}}, lp_state})
        + (($signed({{16{dial_sum[15]}}, dial_sum}) - $signed({{16{lp_state[15]}}, lp_state}))
        >>> `TOS_SHIFT_LOWPASS));

    // Sample pipeline
    always @(posedge clock)
    begin
        if (reset)
        begin
            eq_x1 <= 16'sh0000;
            eq_x2 <= 16'sh0000;
            eq_y1 <= 16'sh0000;
            eq_y2 <= 16'sh0000;
            lp_state <= 16'sh0000;
            tx_tone <= 16'sh0000;
            rx_tone <= 16'sh0000;
            speaker_square <= 1'b0;
            speaker_active <= 1'b0;
        end
        else if (sample_strobe)
        begin
            eq_x1 <= gated_tone;
            eq_x2 <= eq_x1;
            eq_y1 <= eq_out;
            eq_y2 <= eq_y1;
            lp_state <= dial_tone_mode ? lp_next : 16'sh0000;
            if (dial_tone_mode)
                tx_tone <= lp_next;
            else
                tx_tone <= tone_to_tx ? tx_scaled : 16'sh0000;
            rx_tone <= tone_to_rx ? rx_scaled : 16'sh0000;
            speaker_square <= direct_speaker_route & gate & ~raw_tone[15];
            speaker_active <= direct_speaker_route & gate;
        end
    end
endmodule // tos_output_stage
`default_nettype wire

// File: tos_output_stage_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tos_output_stage_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sample_strobe,
    input wire logic signed [15:0] tx_tone,
    input wire logic signed [15:0] rx_tone,
    input wire logic speaker_active
);
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (reset);
    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data outside ack");
    unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h18) |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    cfg_width_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h00) |-> wb_dat_o[31:5] == 27'h0)
        else $error("config upper bits not zero");
    sw_width_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h04) |-> wb_dat_o[31:5] == 27'h0)
        else $error("switch upper bits not zero");
    tone_hold_a: assert property (!sample_strobe |=> $stable(tx_tone) && $stable(rx_tone))
        else $error("tone output moved without strobe");
    write_c: cover property (wb_ack_o && $past(wb_we_i));
    strobe_c: cover property (sample_strobe ##1 tx_tone != 16'sh0000);
    speaker_c: cover property ($rose(speaker_active));
endmodule // tos_output_stage_monitor
`default_nettype wire

// File: tos_regs.vh
`ifndef TOS_REGS_VH
`define TOS_REGS_VH

// Register byte offsets
`define TOS_ADR_CONFIG 8'h00
`define TOS_ADR_SWITCH 8'h04
`define TOS_ADR_ON_PERIOD 8'h08
`define TOS_ADR_OFF_PERIOD 8'h0C
`define TOS_ADR_FILTER 8'h10
`define TOS_ADR_LEVELS 8'h14
`define TOS_ADR_STATUS 8'h18

// tone_config_reg bits
`define TOS_CFG_TONE_ENABLE 0
`define TOS_CFG_PULSED_MODE 1
`define TOS_CFG_STOP_AT_END 2
`define TOS_CFG_WAVEFORM_SELECT 3
`define TOS_CFG_FILTER_INSERT 4
`define TOS_CFG_WIDTH 5

// tone_switch_reg bits
`define TOS_SW_TONE_TO_TX 0
`define TOS_SW_TONE_TO_RX 1
`define TOS_SW_DIRECT_SPEAKER 2
`define TOS_SW_DIAL_TONE_MODE 3
`define TOS_SW_ADD_EXTRA_GEN 4
`define TOS_SW_WIDTH 5

// Byte fields of the filter and level words
`define TOS_BYTE0 7:0
`define TOS_BYTE1 15:8
`define TOS_BYTE2 23:16
`define TOS_BYTE3 31:24
`define TOS_HALF0 15:0

// Status fields
`define TOS_ST_GATE 0
`define TOS_ST_OFF_PHASE 1
`define TOS_ST_DRAINING 2
`define TOS_ST_COUNT_LSB 8

// Reset values
`define TOS_RST_WORD 32'h00000000
`define TOS_RST_PERIOD 16'h0001

// Period unit of the on/off coefficients
`define TOS_UNIT_US 20000
`define TOS_CLK_MHZ 40
`define TOS_UNIT_CYCLES (`TOS_UNIT_US * `TOS_CLK_MHZ)

// Fixed point shifts of the coefficient bytes and of the dial-tone low-pass
`define TOS_SHIFT_LEVEL 8
`define TOS_SHIFT_SAT 6
`define TOS_SHIFT_CENTRE 6
`define TOS_SHIFT_BAND 7
`define TOS_SHIFT_ATTEN 8
`define TOS_SHIFT_LOWPASS 2

`endif

// File: tos_scale.v
`timescale 1ns/1ps
`default_nettype none

module tos_scale #(
    parameter SHIFT = 8
) (
    input wire signed [15:0] sample,
    input wire [7:0] coef,
    output reg signed [15:0] scaled
);
    reg signed [25:0] prod;

    // Multiply by an unsigned byte, shift, clip at full scale
    always @*
    begin
        prod = sample * $signed({1'b0, coef});
        prod = prod >>> SHIFT;
        if (prod > 26'sh0007FFF)
            scaled = 16'sh7FFF;
        else if (prod < -26'sh0008000)
            scaled = -16'sh8000;
        else
            scaled = prod[15:0];
    end
endmodule // tos_scale
`default_nettype wire
